// ### acs_pkg.sv
// Purpose: Shared constants for the conversion sequencer.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Register layouts are local choices.
package acs_pkg;
  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] ACS_OFF_CTRL0 = 8'h00;
  localparam logic [7:0] ACS_OFF_CTRL1 = 8'h04;
  localparam logic [7:0] ACS_OFF_RESH = 8'h08;
  localparam logic [7:0] ACS_OFF_RESL = 8'h0C;
  localparam logic [7:0] ACS_OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] ACS_OFF_IRQ_EN = 8'h14;
  localparam logic [7:0] ACS_OFF_IRQ_CLR = 8'h18;
  localparam logic [7:0] ACS_OFF_SAMPLE = 8'h1C;
  // ****************************************************************
  // Field positions of control_reg0 and control_reg1
  // ****************************************************************
  localparam int ACS_C0_CHAN_LSB = 0;
  localparam int ACS_C0_FMT = 4;
  localparam int ACS_C0_PWR = 5;
  localparam int ACS_C0_BUSY = 6;
  localparam int ACS_C0_START = 7;
  localparam int ACS_C1_DIV_LSB = 0;
  localparam int ACS_C1_REF_LSB = 3;
  localparam int ACS_C1_SRC_LSB = 5;
  localparam int ACS_C1_GIE = 8;
  // ****************************************************************
  // Reset values and timing counts
  // ****************************************************************
  localparam logic [7:0] ACS_C0_RST = 8'h00;
  localparam logic [8:0] ACS_C1_RST = 9'h000;
  localparam logic [4:0] ACS_SAMPLE_CYC = 5'd4;
  localparam logic [4:0] ACS_CONV_CYC = 5'd12;
  localparam logic [4:0] ACS_TOTAL_CYC = 5'd16;
  localparam logic [11:0] ACS_FULL_SCALE = 12'hFFF;
  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_ARMED = 2'b01,
    ACS_SAMPLING = 2'b10,
    ACS_CONVERTING = 2'b11
  } acs_state_e;
endpackage

// ### acs_sequencer.sv
// Purpose: Control and sequencing of a 12-bit SAR converter with an APB register file.
// Assumes: pclk at 100 MHz; analog comparator delivers one decision bit per A/D clock.
// Notes: Zero-wait-state APB slave; unmapped addresses read zero, writes ignored.
// ****************************************************************
// Sequencer module
// ****************************************************************
// Contract
// - Sample four, convert twelve, sixteen A/D clocks.
// - Start runs only after full high-low pulse.
// - Busy high during conversion, results then valid.
// - Conversion runs with no software help.
// - Power enable bit gates converter power.
// - Format bit arranges result across bytes.
// - Result is unsigned twelve bits, FFFH full.
// - Divider code gives fsys over two-power.
// - Source codes 000,101-111 route external channel.
// - Completion sets flag and raises enabled interrupt.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
module acs_sequencer (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog front end
  input wire logic cmp_bit,
  output logic analog_power_on,
  output logic sample_hold,
  output logic [3:0] external_channel_select,
  output logic [2:0] internal_source_select,
  output logic [1:0] reference_select,
  output logic [11:0] dac_trial,
  output logic ext_route,
  // Interrupt
  output logic irq
);
  import acs_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] ctrl0_r, ctrl0_nxt;
  logic [8:0] ctrl1_r, ctrl1_nxt;
  logic [11:0] result_r, result_nxt;
  logic [11:0] sar_r, sar_nxt;
  logic irq_stat_r, irq_stat_nxt;
  logic irq_en_r, irq_en_nxt;
  logic busy_r, busy_nxt;
  logic [6:0] div_cnt_r, div_cnt_nxt;
  logic [4:0] step_r, step_nxt;
  acs_state_e state_r, state_nxt;
  logic wr, adck_tick, done;
  logic [6:0] div_limit;
  logic [11:0] bit_mask;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr = psel & penable & pwrite;
  assign div_limit = 7'((8'd1 << ctrl1_r[ACS_C1_DIV_LSB +: 3]) - 8'd1);
  assign adck_tick = (div_cnt_r == div_limit);
  assign bit_mask = 12'h800 >> (step_r - ACS_SAMPLE_CYC);

  // ****************************************************************
  // Register and sequencer next state
  // ****************************************************************
  always_comb begin
    ctrl0_nxt = ctrl0_r;
    ctrl1_nxt = ctrl1_r;
    irq_en_nxt = irq_en_r;
    irq_stat_nxt = irq_stat_r;
    result_nxt = result_r;
    sar_nxt = sar_r;
    busy_nxt = busy_r;
    step_nxt = step_r;
    state_nxt = state_r;
    div_cnt_nxt = adck_tick ? 7'd0 : 7'(div_cnt_r + 7'd1);
    done = 1'b0;
    if (wr && hit(paddr, ACS_OFF_CTRL0)) begin
      ctrl0_nxt = pwdata[7:0];
    end
    if (wr && hit(paddr, ACS_OFF_CTRL1)) begin
      ctrl1_nxt = pwdata[8:0];
    end
    if (wr && hit(paddr, ACS_OFF_IRQ_EN)) begin
      irq_en_nxt = pwdata[0];
    end
    case (state_r)
      ACS_IDLE: begin
        if (ctrl0_nxt[ACS_C0_START] && !ctrl0_r[ACS_C0_START]) begin
          state_nxt = ACS_ARMED;
        end
      end
      ACS_ARMED: begin
        if (!ctrl0_nxt[ACS_C0_START]) begin
          state_nxt = ACS_SAMPLING;
          busy_nxt = 1'b1;
          step_nxt = 5'd0;
          sar_nxt = 12'h000;
          div_cnt_nxt = 7'd0;
        end
      end
      ACS_SAMPLING: begin
        if (adck_tick) begin
          step_nxt = 5'(step_r + 5'd1);
          if (step_r == ACS_SAMPLE_CYC - 5'd1) begin
            state_nxt = ACS_CONVERTING;
          end
        end
      end
      ACS_CONVERTING: begin
        if (adck_tick) begin
          // Each A/D clock resolves one bit, MSB first
          sar_nxt = cmp_bit ? (sar_r | bit_mask) : sar_r;
          step_nxt = 5'(step_r + 5'd1);
          if (step_r == ACS_TOTAL_CYC - 5'd1) begin
            done = 1'b1;
            result_nxt = cmp_bit ? (sar_r | bit_mask) : sar_r;
            busy_nxt = 1'b0;
            state_nxt = ACS_IDLE;
          end
        end
      end
      default: state_nxt = ACS_IDLE;
    endcase
    // A new rising edge on start aborts whatever was running.
    if (state_r != ACS_IDLE && ctrl0_nxt[ACS_C0_START] && !ctrl0_r[ACS_C0_START]) begin
      state_nxt = ACS_ARMED;
      busy_nxt = 1'b0;
      done = 1'b0;
      result_nxt = result_r;
    end
    if (!ctrl0_nxt[ACS_C0_PWR]) begin
      state_nxt = ACS_IDLE;
      busy_nxt = 1'b0;
      done = 1'b0;
      result_nxt = result_r;
    end
    // Set wins over a simultaneous clear.
    if (wr && hit(paddr, ACS_OFF_IRQ_CLR) && pwdata[0]) begin
      irq_stat_nxt = 1'b0;
    end
    if (done) begin
      irq_stat_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_r <= ACS_C0_RST;
      ctrl1_r <= ACS_C1_RST;
      irq_en_r <= 1'b0;
      irq_stat_r <= 1'b0;
      result_r <= 12'h000;
      sar_r <= 12'h000;
      busy_r <= 1'b0;
      step_r <= 5'd0;
      div_cnt_r <= 7'd0;
      state_r <= ACS_IDLE;
    end else if (clk_en) begin
      ctrl0_r <= ctrl0_nxt;
      ctrl1_r <= ctrl1_nxt;
      irq_en_r <= irq_en_nxt;
      irq_stat_r <= irq_stat_nxt;
      result_r <= result_nxt;
      sar_r <= sar_nxt;
      busy_r <= busy_nxt;
      step_r <= step_nxt;
      div_cnt_r <= div_cnt_nxt;
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // Read data and outputs
  // ****************************************************************
  logic [7:0] res_hi, res_lo;
  always_comb begin
    if (ctrl0_r[ACS_C0_FMT]) begin
      res_hi = {4'h0, result_r[11:8]};
      res_lo = result_r[7:0];
    end else begin
      res_hi = result_r[11:4];
      res_lo = {result_r[3:0], 4'h0};
    end
    prdata = 32'h0000_0000;
    if (psel) begin
      case (paddr)
        ACS_OFF_CTRL0: prdata = {24'h00_0000, ctrl0_r[7], busy_r, ctrl0_r[5:0]};
        ACS_OFF_CTRL1: prdata = {23'h00_0000, ctrl1_r};
        ACS_OFF_RESH: prdata = {24'h00_0000, res_hi};
        ACS_OFF_RESL: prdata = {24'h00_0000, res_lo};
        ACS_OFF_IRQ_STAT: prdata = {31'h0000_0000, irq_stat_r};
        ACS_OFF_IRQ_EN: prdata = {31'h0000_0000, irq_en_r};
        ACS_OFF_SAMPLE: prdata = {27'h000_0000, step_r};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // Both the global and the local enable gate the line.
  assign irq = irq_stat_r & irq_en_r & ctrl1_r[ACS_C1_GIE];
  assign analog_power_on = ctrl0_r[ACS_C0_PWR];
  assign sample_hold = (state_r == ACS_SAMPLING);
  assign external_channel_select = ctrl0_r[ACS_C0_CHAN_LSB +: 4];
  assign internal_source_select = ctrl1_r[ACS_C1_SRC_LSB +: 3];
  assign reference_select = ctrl1_r[ACS_C1_REF_LSB +: 2];
  assign dac_trial = sar_r | ((state_r == ACS_CONVERTING) ? bit_mask : 12'h000);
  // Internal codes force the pin path off whatever the channel field holds.
  assign ext_route = (internal_source_select == 3'b000) ||
                     (internal_source_select >= 3'b101);
endmodule

// ### acs_sequencer_sva.sv
// Purpose: Port-level checks on the conversion sequencer.
// Assumes: clk_en is held high; busy is seen only through control_reg0 reads.
// Notes: Timing bounds allow the slowest divider code plus one tick of alignment.
module acs_sequencer_sva (
  // Clock and APB
  input wire logic pclk, presetn, psel, penable, pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // Front end and interrupt
  input wire logic sample_hold, analog_power_on, ext_route, irq,
  input wire logic [2:0] internal_source_select
);
  import acs_pkg::*;
  // ****************************************************************
  // Helpers and assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_any, wr_c0, pwr_bit;
  assign wr_any = psel && penable && pwrite;
  assign wr_c0 = wr_any && (paddr == ACS_OFF_CTRL0);
  assign pwr_bit = pwdata[ACS_C0_PWR];
  AST_SH_MIN: assert property ($rose(sample_hold) |-> sample_hold[*4])
    else $error("sampling phase too short");
  AST_SH_MAX: assert property ($rose(sample_hold) |-> ##[3:700] !sample_hold)
    else $error("sampling phase too long");
  AST_PWR_FOLLOW: assert property (wr_c0 |=> analog_power_on == $past(pwr_bit))
    else $error("power output does not follow its bit");
  AST_PWR_IDLE: assert property (!analog_power_on && !$past(analog_power_on) |-> !sample_hold)
    else $error("sampling while powered down");
  AST_ROUTE: assert property (ext_route == (internal_source_select == 3'b000 ||
    internal_source_select >= 3'b101)) else $error("external route decode wrong");
  AST_BUSY_READ: assert property (psel && penable && !pwrite && paddr == ACS_OFF_CTRL0 &&
    sample_hold |-> prdata[ACS_C0_BUSY]) else $error("busy not shown while sampling");
  AST_IRQ_HOLD: assert property ($fell(irq) |-> $past(wr_any))
    else $error("interrupt dropped without a write");
  AST_ABORT: assert property (wr_c0 && pwdata[ACS_C0_START] |-> ##[1:2] !sample_hold)
    else $error("start rise did not stop sampling");
  cover property ($rose(sample_hold));
  cover property ($rose(irq));
  cover property ($fell(irq));
endmodule
bind acs_sequencer acs_sequencer_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .sample_hold(sample_hold), .analog_power_on(analog_power_on), .ext_route(ext_route),
  .irq(irq), .internal_source_select(internal_source_select));

// ### acs_sequencer_tb_top.sv
// Purpose: Self-checking bench for the conversion sequencer.
// Assumes: Comparator held steady per conversion, so tick alignment cannot skew results.
// Notes: clk_en is high except during one interrupt-enable write, which the bench checks is lost.
module acs_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import acs_pkg::*;
  // ****************************************************************
  // Signals, rows and design
  // ****************************************************************
  typedef struct packed {logic [2:0] d; logic f; logic c; logic [7:0] h; logic [7:0] l;} acs_row_s;
  logic pclk, presetn, psel, penable, pwrite, cmp_bit, pready, irq, sample_hold, power_on;
  logic clk_en, pslverr, ext_route;
  logic [3:0] chan;
  logic [2:0] src;
  logic [1:0] vref;
  logic [11:0] dac;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int fail_count = 0;
  int checks_done = 0;
  int n;
  acs_row_s rows [4] = '{'{3'd0, 1'b1, 1'b1, 8'h0F, 8'hFF}, '{3'd0, 1'b0, 1'b1, 8'hFF, 8'hF0},
    '{3'd1, 1'b1, 1'b0, 8'h00, 8'h00}, '{3'd2, 1'b0, 1'b1, 8'hFF, 8'hF0}};
  acs_sequencer dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_bit(cmp_bit), .analog_power_on(power_on),
    .sample_hold(sample_hold), .external_channel_select(chan), .internal_source_select(src),
    .reference_select(vref), .dac_trial(dac), .ext_route(ext_route), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  // One idle edge after each transfer keeps drivers from reassigning in one step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic launch(input logic [2:0] d, input logic f, input logic c, input logic en);
    apb(1'b1, ACS_OFF_CTRL1, {23'h0, 1'b1, 5'h0, d});
    apb(1'b1, ACS_OFF_IRQ_EN, {31'h0, en});
    cmp_bit <= c;
    apb(1'b1, ACS_OFF_CTRL0, {24'h0, 1'b0, 1'b0, 1'b1, f, 4'h0});
    repeat (4) @(posedge pclk);
    apb(1'b1, ACS_OFF_CTRL0, {24'h0, 1'b1, 1'b0, 1'b1, f, 4'h0});
    apb(1'b1, ACS_OFF_CTRL0, {24'h0, 1'b0, 1'b0, 1'b1, f, 4'h0});
  endtask
  task automatic finish(input logic [2:0] d, input logic [7:0] h, input logic [7:0] l);
    apb(1'b0, ACS_OFF_CTRL0, 32'h0); chk(q[ACS_C0_BUSY], 1, "busy in run");
    n = 3;
    while (irq !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
    chk(n + 3 >= (16 << d) && n <= (17 << d) + 3, 1, "run length");
    apb(1'b0, ACS_OFF_RESH, 32'h0); chk(q, {24'h0, h}, "result high");
    apb(1'b0, ACS_OFF_RESL, 32'h0); chk(q, {24'h0, l}, "result low");
    apb(1'b0, ACS_OFF_SAMPLE, 32'h0); chk(q, {27'h0, ACS_TOTAL_CYC}, "tick count");
    apb(1'b0, ACS_OFF_CTRL0, 32'h0); chk(q[ACS_C0_BUSY], 0, "busy at end");
    apb(1'b1, ACS_OFF_IRQ_CLR, 32'h1); chk(irq, 0, "irq clear");
  endtask
  task automatic report_and_stop();
    $display("fail_count=%0d checks_done=%0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; cmp_bit = 1'b0; clk_en = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(irq, 0, "irq at reset");
    apb(1'b0, ACS_OFF_CTRL0, 32'h0); chk(q, {24'h0, ACS_C0_RST}, "ctrl0 reset");
    apb(1'b0, ACS_OFF_CTRL1, 32'h0); chk(q, {23'h0, ACS_C1_RST}, "ctrl1 reset");
    foreach (rows[i]) begin
      launch(rows[i].d, rows[i].f, rows[i].c, 1'b1);
      finish(rows[i].d, rows[i].h, rows[i].l);
    end
    chk(dac, ACS_FULL_SCALE, "trial word after all ones");
    chk(pslverr, 0, "no slave error");
    apb(1'b1, ACS_OFF_CTRL0, 32'h80); apb(1'b1, ACS_OFF_CTRL0, 32'h0);
    apb(1'b0, ACS_OFF_CTRL0, 32'h0); chk(q, 0, "start while off");
    chk(power_on, 0, "power off");
    launch(3'd3, 1'b1, 1'b1, 1'b0);
    repeat (100) @(posedge pclk);
    apb(1'b1, ACS_OFF_CTRL0, 32'hB0);
    repeat (2100) @(posedge pclk);
    apb(1'b0, ACS_OFF_IRQ_STAT, 32'h0); chk(q, 0, "abort sets no flag");
    apb(1'b1, ACS_OFF_CTRL0, 32'h30);
    repeat (2300) @(posedge pclk);
    chk(irq, 0, "masked irq");
    apb(1'b0, ACS_OFF_IRQ_STAT, 32'h0); chk(q, 1, "flag set");
    apb(1'b1, ACS_OFF_IRQ_EN, 32'h1); chk(irq, 1, "irq unmasked");
    clk_en <= 1'b0;
    apb(1'b1, ACS_OFF_IRQ_EN, 32'h0);
    clk_en <= 1'b1;
    chk(irq, 1, "frozen write lost");
    apb(1'b0, ACS_OFF_IRQ_EN, 32'h0); chk(q, 1, "enable kept while frozen");
    apb(1'b0, ACS_OFF_RESH, 32'h0); chk(q, 32'h0F, "relaunch result");
    apb(1'b1, ACS_OFF_IRQ_CLR, 32'h1); chk(irq, 0, "irq clear");
    apb(1'b0, 8'h40, 32'h0); chk(q, 0, "unmapped read");
    apb(1'b1, ACS_OFF_CTRL0, 32'h2A); chk(chan, 4'hA, "channel off first");
    apb(1'b1, ACS_OFF_CTRL1, 32'h30); chk(src, 3'b001, "internal source");
    chk(ext_route, 0, "internal route");
    chk(vref, 2'b10, "reference field");
    apb(1'b1, ACS_OFF_CTRL1, 32'hA0); chk(ext_route, 1, "code 101 external");
    apb(1'b1, ACS_OFF_CTRL0, 32'h23); chk(chan, 4'h3, "external channel");
    report_and_stop();
  end
  initial begin
    repeat (12000) @(posedge pclk);
    fail_count++;
    report_and_stop();
  end
endmodule
